// *** event_irq.sv ***
/*
 * Sticky event status with enable mask and one level interrupt.
 * Assumes clear and enable writes arrive as one-cycle strobes.
 */
`timescale 1ns/1ps
module event_irq (
   // Clock and reset
   input  wire logic                                 clk,
   input  wire logic                                 nrst,
   // Events and software access
   input  wire logic [phase_ctl_pkg::EV_COUNT-1:0]   events,
   input  wire logic                                 clr_wr,
   input  wire logic                                 en_wr,
   input  wire logic [phase_ctl_pkg::EV_COUNT-1:0]   wbits,
   // State
   output logic      [phase_ctl_pkg::EV_COUNT-1:0]   status_q,
   output logic      [phase_ctl_pkg::EV_COUNT-1:0]   enable_q,
   output logic                                      irq_q
);
   import phase_ctl_pkg::*;

   logic [EV_COUNT-1:0] status_d;
   logic [EV_COUNT-1:0] enable_d;

   // Set wins over a clear in the same cycle
   always_comb begin
      status_d = (status_q & ~(clr_wr ? wbits : EV_RESET)) | events;
      enable_d = en_wr ? wbits : enable_q;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_q <= EV_RESET;
         enable_q <= EV_RESET;
      end else begin
         status_q <= status_d;
         enable_q <= enable_d;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_d & enable_d);
      end
   end

endmodule

// *** host_model.sv ***
/*
 * Host model on the byte register port.
 * Assumes tasks are entered just after a rising clock edge.
 */
`timescale 1ns/1ps
module host_model (
   // Clock
   input  wire logic                              clk,
   // Register port
   output logic      [phase_ctl_pkg::ADDR_W-1:0]  addr,
   output logic      [phase_ctl_pkg::DATA_W-1:0]  wdata,
   output logic                                   wr,
   output logic                                   rd,
   input  wire logic [phase_ctl_pkg::DATA_W-1:0]  rdata
);
   import phase_ctl_pkg::*;
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end

   // ==========================================================
   // Bus cycles
   // Idle lines toggle so stale values are never mistaken for data
   task automatic idle;
      addr  <= ~addr;
      wdata <= ~wdata;
      wr    <= 1'b0;
      rd    <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
   endtask
   task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
      addr  <= a;
      wdata <= ~wdata;
      wr    <= 1'b0;
      rd    <= 1'b1;
      @(posedge clk);
      rd    <= 1'b0;
      // Read data settle mid-cycle, clear of the edge race
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask

   // ==========================================================
   // Host duties
   task automatic set_osc(input logic ext);
      wr_byte(OSC_SEL_ADDR, {7'h00, ext});
   endtask
   task automatic lock_clear(input logic on);
      wr_byte(LOCK_CLR_ADDR, on ? 8'h08 : 8'h00);
   endtask
endmodule

// *** phase_ctl_pkg.sv ***
/*
 * Constants, register map and quadrature decode for the post-divider
 * phase control block.
 * Assumes byte-wide register access over a plain strobe port.
 */
package phase_ctl_pkg;

   // ==========================================================
   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // ==========================================================
   // Phase word layout
   localparam int DIV_COUNT = 11;
   localparam int WORD_W    = 16;
   localparam int COARSE_LSB = 0;
   localparam int COARSE_W   = 13;
   localparam int QUAD_LSB   = 13;
   localparam int QUAD_W     = 3;
   localparam int STEPS_W    = 4;
   localparam logic [WORD_W-1:0] PHASE_RESET = 16'h0000;

   // Low byte address of each phase word; high byte follows it
   localparam logic [ADDR_W-1:0] PHASE_ADDR [DIV_COUNT] = '{
      8'hbf, 8'hc1, 8'hc7, 8'hc9, 8'hcb, 8'hcd,
      8'hcf, 8'hd1, 8'hd3, 8'hd5, 8'hd7};
   localparam logic [ADDR_W-1:0] HI_BYTE_STEP = 8'h01;

   // ==========================================================
   // Other registers
   localparam logic [ADDR_W-1:0] LOCK_CLR_ADDR = 8'hba;
   localparam int                LOCK_CLR_BIT  = 3;
   localparam logic [ADDR_W-1:0] OSC_SEL_ADDR  = 8'hc3;
   localparam int                OSC_SEL_BIT   = 0;
   localparam logic              OSC_SEL_RESET = 1'b0;
   localparam logic [ADDR_W-1:0] REV2_ADDR     = 8'hc6;
   localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 8'hf0;
   localparam logic [ADDR_W-1:0] IRQ_CLR_ADDR  = 8'hf1;
   localparam logic [ADDR_W-1:0] IRQ_EN_ADDR   = 8'hf2;

   // ==========================================================
   // Event bits
   localparam int EV_COUNT     = 4;
   localparam int EV_COMMIT    = 0;
   localparam int EV_ORPHAN_HI = 1;
   localparam int EV_OSC_CHG   = 2;
   localparam int EV_LOCK_CLR  = 3;
   localparam logic [EV_COUNT-1:0] EV_RESET = 4'h0;

   // ==========================================================
   // Quadrature codes
   localparam logic [QUAD_W-1:0] QUAD_NONE = 3'h0;
   localparam logic [QUAD_W-1:0] QUAD_M45  = 3'h1;
   localparam logic [QUAD_W-1:0] QUAD_M90  = 3'h2;
   localparam logic [QUAD_W-1:0] QUAD_M135 = 3'h3;
   localparam logic [QUAD_W-1:0] QUAD_180  = 3'h4;
   localparam logic [QUAD_W-1:0] QUAD_P135 = 3'h5;
   localparam logic [QUAD_W-1:0] QUAD_P90  = 3'h6;
   localparam logic [QUAD_W-1:0] QUAD_P45  = 3'h7;

   // Signed count of 45 degree steps for a quadrature code
   function automatic logic signed [STEPS_W-1:0] quad_steps(input logic [QUAD_W-1:0] code);
      case (code)
         QUAD_NONE: quad_steps = 4'sh0;
         QUAD_M45:  quad_steps = -4'sh1;
         QUAD_M90:  quad_steps = -4'sh2;
         QUAD_M135: quad_steps = -4'sh3;
         QUAD_180:  quad_steps = 4'sh4;
         QUAD_P135: quad_steps = 4'sh3;
         QUAD_P90:  quad_steps = 4'sh2;
         QUAD_P45:  quad_steps = 4'sh1;
         default:   quad_steps = 4'sh0;
      endcase
   endfunction

endpackage

// *** phase_shift_checker.sv ***
/*
 * Port checker for the phase control bank.
 * Bound into phase_shift_ctl; sees only its ports.
 */
`timescale 1ns/1ps
module phase_shift_checker #(
   parameter logic [7:0] REVISION_CODE = 8'h5a
) (
   // Clock and reset
   input wire logic                                clk,
   input wire logic                                nrst,
   // Register port
   input wire logic [phase_ctl_pkg::ADDR_W-1:0]    addr,
   input wire logic [phase_ctl_pkg::DATA_W-1:0]    wdata,
   input wire logic                                wr,
   input wire logic                                rd,
   input wire logic [phase_ctl_pkg::DATA_W-1:0]    rdata,
   // Outputs under watch
   input wire logic                                osc_driver_en,
   input wire logic                                synth3_lock_loss_clear,
   input wire logic                                irq,
   input wire logic [phase_ctl_pkg::COARSE_W-1:0]  synth0_div_d_coarse_offset,
   input wire logic [phase_ctl_pkg::QUAD_W-1:0]    synth0_div_d_quadrature,
   input wire logic [phase_ctl_pkg::STEPS_W-1:0]   synth0_div_d_quad_steps
);
   import phase_ctl_pkg::*;

   // ==========================================================
   // Properties
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence s_word;
      wr && addr == PHASE_ADDR[1] ##1 wr && addr == PHASE_ADDR[1] + HI_BYTE_STEP;
   endsequence
   sequence s_osc_wr;
      wr && addr == OSC_SEL_ADDR ##1 !(wr && addr == OSC_SEL_ADDR);
   endsequence
   sequence s_clr_wr;
      wr && addr == LOCK_CLR_ADDR ##1 !(wr && addr == LOCK_CLR_ADDR);
   endsequence

   property p_coarse;
      s_word |=> synth0_div_d_coarse_offset == {$past(wdata[4:0]), $past(wdata, 2)};
   endproperty
   property p_quad;
      s_word |=> synth0_div_d_quadrature == $past(wdata[7:5]);
   endproperty
   property p_steps;
      $changed(synth0_div_d_quadrature) |=> synth0_div_d_quad_steps ==
         ($past(synth0_div_d_quadrature) > 3'h3 ? 4'h8 : 4'h0) - {1'b0, $past(synth0_div_d_quadrature)};
   endproperty
   property p_half;
      wr && addr == PHASE_ADDR[1] |=> $stable(synth0_div_d_coarse_offset) && $stable(synth0_div_d_quadrature);
   endproperty
   property p_osc;
      s_osc_wr |=> osc_driver_en == !$past(wdata[OSC_SEL_BIT], 2);
   endproperty
   property p_lock;
      s_clr_wr |=> synth3_lock_loss_clear == $past(wdata[LOCK_CLR_BIT], 2);
   endproperty
   property p_rev;
      rd && addr == REV2_ADDR |=> rdata == REVISION_CODE;
   endproperty
   property p_idle;
      !rd |=> rdata == 8'h00;
   endproperty
   property p_mask;
      wr && addr == IRQ_EN_ADDR && wdata == 8'h00 |=> !irq;
   endproperty

   a_coarse: assert property (p_coarse) else $error("coarse wrong");
   a_quad: assert property (p_quad) else $error("quad wrong");
   a_steps: assert property (p_steps) else $error("steps wrong");
   a_half: assert property (p_half) else $error("half word applied");
   a_osc: assert property (p_osc) else $error("osc wrong");
   a_lock: assert property (p_lock) else $error("lock wrong");
   a_rev: assert property (p_rev) else $error("rev wrong");
   a_idle: assert property (p_idle) else $error("rdata not idle");
   a_mask: assert property (p_mask) else $error("irq unmasked");
endmodule

bind phase_shift_ctl phase_shift_checker #(.REVISION_CODE(REVISION_CODE)) chk_u (
   .clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .osc_driver_en, .synth3_lock_loss_clear, .irq,
   .synth0_div_d_coarse_offset, .synth0_div_d_quadrature, .synth0_div_d_quad_steps);

// *** phase_shift_ctl.sv ***
/*
 * Register bank for coarse and quadrature phase shift of the synthesizer
 * post-dividers, oscillator driver select, secondary revision and the
 * synthesizer 3 lock-loss clear bit.
 * Assumes a byte-wide strobe port; read data stand one cycle after the read.
 */
// The address-and-strobe port is this design's own decision.
// Behaviour
// - Low thirteen bits are a signed count of synthesizer periods of shift.
// - Zero no shift; negative delays, positive advances, by that many periods.
// - Top three bits pick an extra quadrature shift in 45 degree steps.
// - Codes 000 0, 001 -45, 010 -90, 100 180, 101 +135, 110 +90, 111 +45.
// - Both settings apply together to all clocks of that post-divider.
// - Oscillator select bit zero clear enables the driver, set disables it.
// - Fixed eight-bit secondary revision code is readable.
// - Clear register bit three clears synthesizer 3 lock-loss sticky flag.
`timescale 1ns/1ps
module phase_shift_ctl #(
   // Arbitrary neutral value
   parameter logic [7:0] REVISION_CODE = 8'h5a
) (
   // Clock and reset
   input  wire logic                                   clk,
   input  wire logic                                   nrst,
   // Register port
   input  wire logic [phase_ctl_pkg::ADDR_W-1:0]       addr,
   input  wire logic [phase_ctl_pkg::DATA_W-1:0]       wdata,
   input  wire logic                                   wr,
   input  wire logic                                   rd,
   output logic      [phase_ctl_pkg::DATA_W-1:0]       rdata,
   // Oscillator, lock-loss and interrupt
   output logic                                        osc_driver_en,
   output logic                                        synth3_lock_loss_clear,
   output logic                                        irq,
   // Synthesizer 0
   output logic      [phase_ctl_pkg::COARSE_W-1:0]     synth0_div_c_coarse_offset,
   output logic      [phase_ctl_pkg::QUAD_W-1:0]       synth0_div_c_quadrature,
   output logic      [phase_ctl_pkg::STEPS_W-1:0]      synth0_div_c_quad_steps,
   output logic      [phase_ctl_pkg::COARSE_W-1:0]     synth0_div_d_coarse_offset,
   output logic      [phase_ctl_pkg::QUAD_W-1:0]       synth0_div_d_quadrature,
   output logic      [phase_ctl_pkg::STEPS_W-1:0]      synth0_div_d_quad_steps,
   // Synthesizer 1
   output logic      [phase_ctl_pkg::COARSE_W-1:0]     synth1_div_c_coarse_offset,
   output logic      [phase_ctl_pkg::QUAD_W-1:0]       synth1_div_c_quadrature,
   output logic      [phase_ctl_pkg::STEPS_W-1:0]      synth1_div_c_quad_steps,
   output logic      [phase_ctl_pkg::COARSE_W-1:0]     synth1_div_d_coarse_offset,
   output logic      [phase_ctl_pkg::QUAD_W-1:0]       synth1_div_d_quadrature,
   output logic      [phase_ctl_pkg::STEPS_W-1:0]      synth1_div_d_quad_steps,
   // Synthesizer 2
   output logic      [phase_ctl_pkg::COARSE_W-1:0]     synth2_div_a_coarse_offset,
   output logic      [phase_ctl_pkg::QUAD_W-1:0]       synth2_div_a_quadrature,
   output logic      [phase_ctl_pkg::STEPS_W-1:0]      synth2_div_a_quad_steps,
   output logic      [phase_ctl_pkg::COARSE_W-1:0]     synth2_div_b_coarse_offset,
   output logic      [phase_ctl_pkg::QUAD_W-1:0]       synth2_div_b_quadrature,
   output logic      [phase_ctl_pkg::STEPS_W-1:0]      synth2_div_b_quad_steps,
   output logic      [phase_ctl_pkg::COARSE_W-1:0]     synth2_div_c_coarse_offset,
   output logic      [phase_ctl_pkg::QUAD_W-1:0]       synth2_div_c_quadrature,
   output logic      [phase_ctl_pkg::STEPS_W-1:0]      synth2_div_c_quad_steps,
   output logic      [phase_ctl_pkg::COARSE_W-1:0]     synth2_div_d_coarse_offset,
   output logic      [phase_ctl_pkg::QUAD_W-1:0]       synth2_div_d_quadrature,
   output logic      [phase_ctl_pkg::STEPS_W-1:0]      synth2_div_d_quad_steps,
   // Synthesizer 3
   output logic      [phase_ctl_pkg::COARSE_W-1:0]     synth3_div_a_coarse_offset,
   output logic      [phase_ctl_pkg::QUAD_W-1:0]       synth3_div_a_quadrature,
   output logic      [phase_ctl_pkg::STEPS_W-1:0]      synth3_div_a_quad_steps,
   output logic      [phase_ctl_pkg::COARSE_W-1:0]     synth3_div_b_coarse_offset,
   output logic      [phase_ctl_pkg::QUAD_W-1:0]       synth3_div_b_quadrature,
   output logic      [phase_ctl_pkg::STEPS_W-1:0]      synth3_div_b_quad_steps,
   output logic      [phase_ctl_pkg::COARSE_W-1:0]     synth3_div_c_coarse_offset,
   output logic      [phase_ctl_pkg::QUAD_W-1:0]       synth3_div_c_quadrature,
   output logic      [phase_ctl_pkg::STEPS_W-1:0]      synth3_div_c_quad_steps
);
   import phase_ctl_pkg::*;

   // ==========================================================
   // Local state
   logic [WORD_W-1:0]         word_q  [DIV_COUNT];
   logic signed [STEPS_W-1:0] steps_q [DIV_COUNT];
   logic [DIV_COUNT-1:0]      lo_wr;
   logic [DIV_COUNT-1:0]      hi_wr;
   logic [DIV_COUNT-1:0]      commit;
   logic [DIV_COUNT-1:0]      orphan;
   logic                      osc_sel_q;
   logic                      osc_drv_q;
   logic                      lock_clr_q;
   logic [DATA_W-1:0]         rdata_q;
   logic [DATA_W-1:0]         rdata_d;
   logic [EV_COUNT-1:0]       events;
   logic [EV_COUNT-1:0]       ev_status;
   logic [EV_COUNT-1:0]       ev_enable;
   logic                      irq_q;

   // ==========================================================
   // Phase words, one per post-divider
   generate
      for (genvar i = 0; i < DIV_COUNT; i++) begin : g_div
         assign lo_wr[i] = wr && (addr == PHASE_ADDR[i]);
         assign hi_wr[i] = wr && (addr == PHASE_ADDR[i] + HI_BYTE_STEP);

         phase_word_reg u_word (
            .clk    (clk),
            .nrst   (nrst),
            .lo_wr  (lo_wr[i]),
            .hi_wr  (hi_wr[i]),
            .wdata  (wdata),
            .word_q (word_q[i]),
            .commit (commit[i]),
            .orphan (orphan[i])
         );

         // Quadrature code to signed 45 degree steps; 011 is -135 on all
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               steps_q[i] <= '0;
            end else begin
               steps_q[i] <= quad_steps(word_q[i][QUAD_LSB +: QUAD_W]);
            end
         end
      end
   endgenerate

   // ==========================================================
   // Oscillator select and driver enable
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         osc_sel_q <= OSC_SEL_RESET;
         osc_drv_q <= ~OSC_SEL_RESET;
      end else if (wr && addr == OSC_SEL_ADDR) begin
         osc_sel_q <= wdata[OSC_SEL_BIT];
         osc_drv_q <= ~wdata[OSC_SEL_BIT];
      end
   end

   // ==========================================================
   // Synthesizer 3 lock-loss clear, held as a level
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lock_clr_q <= 1'b0;
      end else if (wr && addr == LOCK_CLR_ADDR) begin
         lock_clr_q <= wdata[LOCK_CLR_BIT];
      end
   end

   // ==========================================================
   // Events for the interrupt block
   always_comb begin
      events               = EV_RESET;
      events[EV_COMMIT]    = |commit;
      events[EV_ORPHAN_HI] = |orphan;
      events[EV_OSC_CHG]   = wr && addr == OSC_SEL_ADDR && wdata[OSC_SEL_BIT] != osc_sel_q;
      events[EV_LOCK_CLR]  = wr && addr == LOCK_CLR_ADDR && wdata[LOCK_CLR_BIT] && !lock_clr_q;
   end

   event_irq u_irq (
      .clk      (clk),
      .nrst     (nrst),
      .events   (events),
      .clr_wr   (wr && addr == IRQ_CLR_ADDR),
      .en_wr    (wr && addr == IRQ_EN_ADDR),
      .wbits    (wdata[EV_COUNT-1:0]),
      .status_q (ev_status),
      .enable_q (ev_enable),
      .irq_q    (irq_q)
   );

   // ==========================================================
   // Read decode; unmapped addresses read zero
   always_comb begin
      rdata_d = '0;
      for (int i = 0; i < DIV_COUNT; i++) begin
         if (addr == PHASE_ADDR[i]) begin
            rdata_d = word_q[i][DATA_W-1:0];
         end
         if (addr == PHASE_ADDR[i] + HI_BYTE_STEP) begin
            rdata_d = word_q[i][WORD_W-1:DATA_W];
         end
      end
      case (addr)
         OSC_SEL_ADDR: begin
            rdata_d[OSC_SEL_BIT] = osc_sel_q;
         end
         LOCK_CLR_ADDR: begin
            rdata_d[LOCK_CLR_BIT] = lock_clr_q;
         end
         REV2_ADDR: begin
            rdata_d = REVISION_CODE;
         end
         IRQ_STAT_ADDR: begin
            rdata_d[EV_COUNT-1:0] = ev_status;
         end
         IRQ_EN_ADDR: begin
            rdata_d[EV_COUNT-1:0] = ev_enable;
         end
         default: begin
            rdata_d = rdata_d;
         end
      endcase
   end

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rd ? rdata_d : '0;
      end
   end

   // ==========================================================
   // Outputs
   assign rdata                  = rdata_q;
   assign osc_driver_en          = osc_drv_q;
   assign synth3_lock_loss_clear = lock_clr_q;
   assign irq                    = irq_q;

   // Raw signed coarse count; whole word moves together
   assign synth0_div_c_coarse_offset = word_q[0][COARSE_LSB +: COARSE_W];
   assign synth0_div_c_quadrature    = word_q[0][QUAD_LSB +: QUAD_W];
   assign synth0_div_c_quad_steps    = steps_q[0];
   assign synth0_div_d_coarse_offset = word_q[1][COARSE_LSB +: COARSE_W];
   assign synth0_div_d_quadrature    = word_q[1][QUAD_LSB +: QUAD_W];
   assign synth0_div_d_quad_steps    = steps_q[1];
   assign synth1_div_c_coarse_offset = word_q[2][COARSE_LSB +: COARSE_W];
   assign synth1_div_c_quadrature    = word_q[2][QUAD_LSB +: QUAD_W];
   assign synth1_div_c_quad_steps    = steps_q[2];
   assign synth1_div_d_coarse_offset = word_q[3][COARSE_LSB +: COARSE_W];
   assign synth1_div_d_quadrature    = word_q[3][QUAD_LSB +: QUAD_W];
   assign synth1_div_d_quad_steps    = steps_q[3];
   assign synth2_div_a_coarse_offset = word_q[4][COARSE_LSB +: COARSE_W];
   assign synth2_div_a_quadrature    = word_q[4][QUAD_LSB +: QUAD_W];
   assign synth2_div_a_quad_steps    = steps_q[4];
   assign synth2_div_b_coarse_offset = word_q[5][COARSE_LSB +: COARSE_W];
   assign synth2_div_b_quadrature    = word_q[5][QUAD_LSB +: QUAD_W];
   assign synth2_div_b_quad_steps    = steps_q[5];
   assign synth2_div_c_coarse_offset = word_q[6][COARSE_LSB +: COARSE_W];
   assign synth2_div_c_quadrature    = word_q[6][QUAD_LSB +: QUAD_W];
   assign synth2_div_c_quad_steps    = steps_q[6];
   assign synth2_div_d_coarse_offset = word_q[7][COARSE_LSB +: COARSE_W];
   assign synth2_div_d_quadrature    = word_q[7][QUAD_LSB +: QUAD_W];
   assign synth2_div_d_quad_steps    = steps_q[7];
   assign synth3_div_a_coarse_offset = word_q[8][COARSE_LSB +: COARSE_W];
   assign synth3_div_a_quadrature    = word_q[8][QUAD_LSB +: QUAD_W];
   assign synth3_div_a_quad_steps    = steps_q[8];
   assign synth3_div_b_coarse_offset = word_q[9][COARSE_LSB +: COARSE_W];
   assign synth3_div_b_quadrature    = word_q[9][QUAD_LSB +: QUAD_W];
   assign synth3_div_b_quad_steps    = steps_q[9];
   assign synth3_div_c_coarse_offset = word_q[10][COARSE_LSB +: COARSE_W];
   assign synth3_div_c_quadrature    = word_q[10][QUAD_LSB +: QUAD_W];
   assign synth3_div_c_quad_steps    = steps_q[10];

endmodule

// *** phase_word_reg.sv ***
/*
 * One sixteen-bit phase word written as two bytes, applied whole.
 * Assumes the low byte is written before the high byte.
 */
`timescale 1ns/1ps
module phase_word_reg (
   // Clock and reset
   input  wire logic                               clk,
   input  wire logic                               nrst,
   // Byte writes
   input  wire logic                               lo_wr,
   input  wire logic                               hi_wr,
   input  wire logic [phase_ctl_pkg::DATA_W-1:0]   wdata,
   // Word and events
   output logic      [phase_ctl_pkg::WORD_W-1:0]   word_q,
   output logic                                    commit,
   output logic                                    orphan
);
   import phase_ctl_pkg::*;

   logic [DATA_W-1:0] stage_q;
   logic              pend_q;

   // ==========================================================
   // Low byte staging
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stage_q <= '0;
         pend_q  <= 1'b0;
      end else if (lo_wr) begin
         stage_q <= wdata;
         pend_q  <= 1'b1;
      end else if (hi_wr) begin
         pend_q  <= 1'b0;
      end
   end

   // ==========================================================
   // Whole-word update on the high byte
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         word_q <= PHASE_RESET;
      end else if (hi_wr) begin
         word_q <= {wdata, pend_q ? stage_q : word_q[DATA_W-1:0]};
      end
   end

   assign commit = hi_wr;
   assign orphan = hi_wr & ~pend_q;

endmodule

// *** postdivider_phase_shift_control_tb.sv ***
/*
 * Self-checking bench of the phase control bank.
 * Assumes host_model on the port and a bound checker.
 */
`timescale 1ns/1ps
module postdivider_phase_shift_control_tb;
   import phase_ctl_pkg::*;
   localparam logic [7:0] REV = 8'h3c; // Arbitrary value
   localparam logic [15:0] CORNER [4] = '{16'h0000, 16'h1fff, 16'h1000, 16'h0fff};
   logic clk;
   logic nrst = 1'b0;
   logic [7:0] addr, wdata, rdata;
   logic wr, rd, osc_driver_en, synth3_lock_loss_clear, irq;
   logic [COARSE_W-1:0] synth0_div_c_coarse_offset, synth0_div_d_coarse_offset, synth1_div_c_coarse_offset,
      synth1_div_d_coarse_offset, synth2_div_a_coarse_offset, synth2_div_b_coarse_offset, synth2_div_c_coarse_offset,
      synth2_div_d_coarse_offset, synth3_div_a_coarse_offset, synth3_div_b_coarse_offset, synth3_div_c_coarse_offset;
   logic [QUAD_W-1:0] synth0_div_c_quadrature, synth0_div_d_quadrature, synth1_div_c_quadrature,
      synth1_div_d_quadrature, synth2_div_a_quadrature, synth2_div_b_quadrature, synth2_div_c_quadrature,
      synth2_div_d_quadrature, synth3_div_a_quadrature, synth3_div_b_quadrature, synth3_div_c_quadrature;
   logic [STEPS_W-1:0] synth0_div_c_quad_steps, synth0_div_d_quad_steps, synth1_div_c_quad_steps,
      synth1_div_d_quad_steps, synth2_div_a_quad_steps, synth2_div_b_quad_steps, synth2_div_c_quad_steps,
      synth2_div_d_quad_steps, synth3_div_a_quad_steps, synth3_div_b_quad_steps, synth3_div_c_quad_steps;
   int error_cnt = 0;
   int tests_run = 0;
   logic [31:0] seed = 32'h0000_0017;

   phase_shift_ctl #(.REVISION_CODE(REV)) dut_u (.*);
   host_model h (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ==========================================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [3:0] steps_exp(input logic [2:0] c);
      return {c[2], 3'h0} - {1'b0, c};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic settle;
      h.idle();
      @(posedge clk);
   endtask
   task automatic wr_word(input logic [7:0] a, input logic [15:0] w);
      h.wr_byte(a, w[7:0]);
      h.wr_byte(a + HI_BYTE_STEP, w[15:8]);
      settle();
   endtask
   task automatic rd_word(input logic [7:0] a, output logic [15:0] w);
      logic [7:0] lo, hi;
      h.rd_byte(a, lo);
      h.rd_byte(a + HI_BYTE_STEP, hi);
      w = {hi, lo};
   endtask
   task automatic end_sim;
      $display("Counts: %0d compares, %0d mismatches", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   initial begin
      logic [15:0] w, v;
      logic [7:0] b;
      repeat (8) @(posedge clk);
      chk(osc_driver_en, 1'b1, "osc rst");
      nrst <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < DIV_COUNT; i++) begin
         rd_word(PHASE_ADDR[i], w);
         chk(w, PHASE_RESET, "phase rst");
      end
      h.rd_byte(REV2_ADDR, b);
      chk(b, REV, "rev");
      h.wr_byte(REV2_ADDR, 8'hff);
      h.rd_byte(REV2_ADDR, b);
      chk(b, REV, "rev ro");
      h.rd_byte(8'hfe, b);
      chk(b, 8'h00, "unmapped");
      $display("test reset values done");
      for (int c = 0; c < 12; c++) begin
         seed = xs(seed);
         w = (c < 4) ? CORNER[c] : {3'(c - 4), seed[12:0]};
         wr_word(PHASE_ADDR[1], w);
         chk(synth0_div_d_coarse_offset, w[12:0], "coarse");
         chk(synth0_div_d_quadrature, w[15:13], "quadrature");
         chk(synth0_div_d_quad_steps, steps_exp(w[15:13]), "steps");
      end
      $display("test quadrature codes done");
      for (int i = 0; i < DIV_COUNT; i++) begin
         seed = xs(seed);
         wr_word(PHASE_ADDR[i], seed[15:0]);
         rd_word(PHASE_ADDR[i], v);
         chk(v, seed[15:0], "readback");
      end
      $display("test all dividers done");
      wr_word(PHASE_ADDR[0], 16'h2345);
      h.wr_byte(PHASE_ADDR[0], 8'hee);
      settle();
      chk(synth0_div_c_coarse_offset, 13'h0345, "half held");
      h.wr_byte(IRQ_EN_ADDR, 8'h02);
      h.wr_byte(IRQ_CLR_ADDR, 8'h0f);
      settle();
      chk(irq, 1'b0, "irq clr");
      h.wr_byte(PHASE_ADDR[0] + HI_BYTE_STEP, 8'hc1);
      h.wr_byte(PHASE_ADDR[0] + HI_BYTE_STEP, 8'h7f);
      settle();
      chk(synth0_div_c_coarse_offset, 13'h1fee, "hi alone");
      chk(irq, 1'b1, "irq set");
      h.rd_byte(IRQ_STAT_ADDR, b);
      chk(b & 8'h03, 8'h03, "status");
      h.wr_byte(IRQ_EN_ADDR, 8'h00);
      settle();
      chk(irq, 1'b0, "irq mask");
      h.wr_byte(IRQ_CLR_ADDR, 8'h02);
      h.rd_byte(IRQ_STAT_ADDR, b);
      chk(b & 8'h02, 8'h00, "status clr");
      $display("test words and interrupt done");
      h.set_osc(1'b1);
      settle();
      chk(osc_driver_en, 1'b0, "osc off");
      h.wr_byte(OSC_SEL_ADDR, 8'hfe);
      h.rd_byte(OSC_SEL_ADDR, b);
      chk(b, 8'h00, "osc bits");
      chk(osc_driver_en, 1'b1, "osc on");
      h.wr_byte(LOCK_CLR_ADDR, 8'hff);
      settle();
      chk(synth3_lock_loss_clear, 1'b1, "lock set");
      h.rd_byte(LOCK_CLR_ADDR, b);
      chk(b, 8'h08, "lock reg");
      h.lock_clear(1'b0);
      settle();
      chk(synth3_lock_loss_clear, 1'b0, "lock low");
      h.set_osc(1'b1);
      settle();
      $display("test oscillator and lock done");
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk(osc_driver_en, 1'b1, "osc rst2");
      chk(synth0_div_d_coarse_offset, 13'h0000, "coarse rst2");
      $display("test second reset done");
      end_sim();
   end

   initial begin
      #20000;
      error_cnt++;
      end_sim();
   end
endmodule
